// ===== async_rx_pkg.sv
// Package for the asynchronous serial receiver: register map, field positions,
// reset values, sampling constants and receiver states.
// Assumes a 32-bit APB slave with word-aligned registers.
package async_rx_pkg;
    // Register byte offsets
    localparam logic [7:0] ctrl_offset = 8'h00;
    localparam logic [7:0] baud_offset = 8'h04;
    localparam logic [7:0] data_offset = 8'h08;
    localparam logic [7:0] status_offset = 8'h0C;
    localparam logic [7:0] int_status_offset = 8'h10;
    localparam logic [7:0] int_clear_offset = 8'h14;
    localparam logic [7:0] int_enable_offset = 8'h18;
    // Control field positions
    localparam int ctrl_receive_enable_bit = 0;
    localparam int ctrl_port_enable_bit = 1;
    localparam int ctrl_sync_bit = 2;
    localparam int ctrl_nine_bit = 3;
    // Interrupt / status field positions
    localparam int ev_char_bit = 0;
    localparam int ev_ferr_bit = 1;
    localparam int ev_oerr_bit = 2;
    localparam int st_busy_bit = 3;
    // Reset values
    localparam logic [3:0] ctrl_reset = 4'h0;
    localparam logic [15:0] baud_reset = 16'h0014;
    localparam logic [2:0] int_enable_reset = 3'h0;
    // Sampling: sixteen ticks per bit, start centre after eight ticks
    localparam logic [3:0] last_tick = 4'hF;
    localparam logic [3:0] start_centre = 4'h7;
    localparam logic [3:0] bits_eight = 4'h8;
    localparam logic [3:0] bits_nine = 4'h9;
    localparam logic [1:0] fifo_depth = 2'h2;
    // Receiver states
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_start = 2'b01,
        st_data = 2'b10,
        st_stop = 2'b11
    } rx_state_t;
endpackage : async_rx_pkg

// ===== async_serial_receiver.sv
// Asynchronous serial receive path with 16x oversampling, a two-entry
// character FIFO, framing and overrun detection, and an APB register file.
// Assumes pclk at 40 MHz and a serial input arriving from outside the domain.
//
// Behaviour
// RULE1 - Oversample input sixteen times per bit
// RULE2 - Finished character goes into two-entry FIFO
// RULE3 - Third character shifts while FIFO full
// RULE4 - Software sets enable, clears sync, sets port
// RULE5 - Idle falling edge starts a character
// RULE6 - Confirm start low at half bit
// RULE7 - High start centre aborts silently
// RULE8 - Each bit centre majority-voted into shifter
// RULE9 - Low stop sample flags framing error
// RULE10 - Push character and raise receive flag
// RULE11 - Data read returns and removes oldest
// RULE12 - Overrun halts reception until cleared
// RULE13 - Software configures pin as digital input
// RULE14 - Framing error stored per FIFO entry
`timescale 1ns/100ps
module async_serial_receiver (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_receive_pin,
    output logic receive_interrupt_flag,
    output logic irq
);
    import async_rx_pkg::*;

    // Software-visible control
    logic [3:0] ctrl;
    logic [15:0] baud_div;
    logic [2:0] int_status;
    logic [2:0] int_enable;
    // Pin synchroniser and edge history
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic [2:0] vote_hist;
    // Oversampling tick
    logic [15:0] div_cnt;
    logic tick;
    // Receiver engine
    rx_state_t state;
    logic [3:0] tick_cnt;
    logic [3:0] bit_cnt;
    logic [8:0] shreg;
    logic overrun;
    // FIFO: nine data bits plus framing error per entry
    logic [9:0] fifo_mem [0:1];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] fifo_count;
    // Derived strobes
    logic rx_on;
    logic vote;
    logic fall;
    logic centre;
    logic stop_done;
    logic push;
    logic push_ferr;
    logic oerr_event;
    logic [8:0] push_data;
    logic [3:0] data_bits;
    // Bus strobes
    logic setup_acc;
    logic done;
    logic wr_done;
    logic rd_capture_data;
    logic pop_armed;
    logic pop;
    logic unmapped;
    logic [31:0] next_rdata;

    // Receiver runs only when enabled, asynchronous and not overrun
    assign rx_on = ctrl[ctrl_receive_enable_bit] & ctrl[ctrl_port_enable_bit] & ~ctrl[ctrl_sync_bit] & ~overrun;
    assign data_bits = ctrl[ctrl_nine_bit] ? bits_nine : bits_eight;
    // Majority of the last three samples
    assign vote = (vote_hist[0] & vote_hist[1]) | (vote_hist[0] & vote_hist[2]) | (vote_hist[1] & vote_hist[2]);
    assign fall = rx_prev & ~rx_sync;
    // Bit centre reached on this tick
    assign centre = tick & (state == st_start ? tick_cnt == start_centre : tick_cnt == last_tick);
    assign stop_done = rx_on & centre & (state == st_stop);
    assign push = stop_done & (fifo_count != fifo_depth);
    assign oerr_event = stop_done & (fifo_count == fifo_depth);
    assign push_ferr = ~vote;
    assign push_data = ctrl[ctrl_nine_bit] ? shreg : {1'b0, shreg[8:1]};

    // APB phases: answer one cycle into access
    assign setup_acc = psel & penable & ~pready;
    assign done = psel & penable & pready;
    assign wr_done = done & pwrite;
    assign rd_capture_data = setup_acc & ~pwrite & (paddr == data_offset);
    assign pop = done & ~pwrite & pop_armed;
    assign unmapped = (paddr[1:0] != 2'b00) || (paddr > int_enable_offset);

    // Two-flop synchroniser, then edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_meta <= serial_receive_pin;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    // RULE1 sixteen-times tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (div_cnt == 16'h0000) begin
            div_cnt <= baud_div;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt - 16'h0001;
            tick <= 1'b0;
        end
    end

    // RULE8 sample history for voting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vote_hist <= 3'h7;
        end else if (tick) begin
            vote_hist <= {vote_hist[1:0], rx_sync};
        end
    end

    // Receive state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_idle;
            tick_cnt <= 4'h0;
            bit_cnt <= 4'h0;
            shreg <= 9'h000;
        end else if (!rx_on) begin
            // RULE12 disabled or overrun: hold idle
            state <= st_idle;
            tick_cnt <= 4'h0;
        end else begin
            case (state)
                st_idle: begin
                    // RULE5 falling edge opens a character
                    if (fall) begin
                        state <= st_start;
                        tick_cnt <= 4'h0;
                    end
                end
                st_start: begin
                    if (centre) begin
                        // RULE6 RULE7 verify start at its centre
                        state <= vote ? st_idle : st_data;
                        tick_cnt <= 4'h0;
                        bit_cnt <= 4'h0;
                    end else if (tick) begin
                        tick_cnt <= tick_cnt + 4'h1;
                    end
                end
                st_data: begin
                    if (centre) begin
                        // RULE8 shift voted bit, LSB first
                        shreg <= {vote, shreg[8:1]};
                        bit_cnt <= bit_cnt + 4'h1;
                        // RULE3 shifting continues regardless of FIFO level
                        if (bit_cnt == data_bits - 4'h1) begin
                            state <= st_stop;
                        end
                    end
                    if (tick) begin
                        tick_cnt <= tick_cnt + 4'h1;
                    end
                end
                st_stop: begin
                    // RULE9 stop sampled one bit later
                    if (centre) begin
                        state <= st_idle;
                    end
                    if (tick) begin
                        tick_cnt <= tick_cnt + 4'h1;
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // RULE2 RULE14 FIFO write with framing bit
    always_ff @(posedge pclk) begin
        if (push) begin
            fifo_mem[wr_ptr] <= {push_ferr, push_data};
        end
    end

    // FIFO pointers and level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            fifo_count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            // RULE11 read removes the oldest
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            fifo_count <= fifo_count + {1'b0, push} - {1'b0, pop};
        end
    end

    // RULE12 overrun latches, cleared by dropping receive enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun <= 1'b0;
        end else if (oerr_event) begin
            overrun <= 1'b1;
        end else if (!ctrl[ctrl_receive_enable_bit]) begin
            overrun <= 1'b0;
        end
    end

    // Control and enable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= ctrl_reset;
            baud_div <= baud_reset;
            int_enable <= int_enable_reset;
        end else if (wr_done) begin
            if (paddr == ctrl_offset) begin
                ctrl <= pwdata[3:0];
            end
            if (paddr == baud_offset) begin
                baud_div <= pwdata[15:0];
            end
            if (paddr == int_enable_offset) begin
                int_enable <= pwdata[2:0];
            end
        end
    end

    // Sticky events; a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= 3'h0;
        end else begin
            int_status <= (int_status & ~((wr_done && paddr == int_clear_offset) ? pwdata[2:0] : 3'h0))
                | {oerr_event, push & push_ferr, push};
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr)
            ctrl_offset: next_rdata[3:0] = ctrl;
            baud_offset: next_rdata[15:0] = baud_div;
            data_offset: next_rdata[8:0] = (fifo_count != 2'h0) ? fifo_mem[rd_ptr][8:0] : 9'h000;
            status_offset: begin
                next_rdata[ev_char_bit] = fifo_count != 2'h0;
                // RULE14 head entry's framing error
                next_rdata[ev_ferr_bit] = (fifo_count != 2'h0) & fifo_mem[rd_ptr][9];
                next_rdata[ev_oerr_bit] = overrun;
                next_rdata[st_busy_bit] = state != st_idle;
            end
            int_status_offset: next_rdata[2:0] = int_status;
            int_enable_offset: next_rdata[2:0] = int_enable;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // APB answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            pop_armed <= 1'b0;
        end else begin
            pready <= setup_acc;
            pslverr <= setup_acc & unmapped;
            if (setup_acc && !pwrite) begin
                prdata <= next_rdata;
            end
            // Pop only a character actually returned
            pop_armed <= rd_capture_data & (fifo_count != 2'h0);
        end
    end

    // RULE10 flag and interrupt outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_interrupt_flag <= 1'b0;
            irq <= 1'b0;
        end else begin
            receive_interrupt_flag <= (fifo_count + {1'b0, push} - {1'b0, pop}) != 2'h0;
            irq <= |(int_status & int_enable);
        end
    end

    // Checks
    // RULE5 edge start
    edge_start_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        (state == st_idle && rx_on && fall) |=> state == st_start)
        else $error("falling edge did not start a character");
    // RULE6 half-bit wait
    start_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        (state == st_start && tick && tick_cnt != start_centre && rx_on) |=> state == st_start)
        else $error("start left before centre");
    // RULE7 abort silently
    start_abort_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        (state == st_start && centre && vote && rx_on) |=> (state == st_idle && !$rose(int_status[ev_ferr_bit])))
        else $error("high start centre not aborted");
    // RULE8 voted bit shifted
    bit_shift_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        (state == st_data && centre && rx_on) |=> shreg[8] == $past(vote))
        else $error("voted bit not shifted in");
    // RULE1 sixteen ticks per bit
    bit_period_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        (state == st_data && tick && tick_cnt != last_tick && rx_on) |=> bit_cnt == $past(bit_cnt))
        else $error("bit advanced before sixteen ticks");
    // RULE9 framing captured
    stop_frame_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        push |=> fifo_mem[$past(wr_ptr)][9] == $past(~vote))
        else $error("framing error not stored from stop sample");
    // RULE2 push when room
    fifo_push_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        (stop_done && fifo_count < fifo_depth && !pop) |=> fifo_count == $past(fifo_count) + 2'h1)
        else $error("character not moved into FIFO");
    // RULE10 receive flag raised
    rx_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        push |=> receive_interrupt_flag && int_status[ev_char_bit])
        else $error("receive flag not raised");
    // RULE11 read removes one
    fifo_pop_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        (pop && !push) |=> fifo_count == $past(fifo_count) - 2'h1)
        else $error("read did not remove a character");
    // RULE12 overrun halts
    overrun_halt_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        overrun |-> (!push && state == st_idle))
        else $error("reception continued during overrun");

endmodule : async_serial_receiver

// ===== serial_tx_model.sv
// Remote asynchronous serial transmitter driving the receive line.
// Assumes the bench gives the bit period in pclk cycles.
`timescale 1ns/100ps
module serial_tx_model #(
    parameter int BIT_CLKS = 32
) (
    input wire logic pclk,
    output logic line
);
    // Line idles at the mark level
    // line feeds a digital input pin
    initial begin
        line = 1'b1;
    end

    // One bit level held for a whole bit period
    task automatic hold(input logic v);
        @(posedge pclk);
        line <= v;
        repeat (BIT_CLKS - 1) @(posedge pclk);
    endtask : hold

    // Start, data LSB first, stop, then back to idle
    task automatic send(input logic [8:0] data, input int nbits, input logic stop_lvl);
        hold(1'b0);
        for (int i = 0; i < nbits; i++) begin
            hold(data[i]);
        end
        hold(stop_lvl);
        @(posedge pclk);
        line <= 1'b1;
    endtask : send

    // Short low pulse whose start must be aborted, leaving no character
    task automatic glitch(input int n);
        @(posedge pclk);
        line <= 1'b0;
        repeat (n) @(posedge pclk);
        line <= 1'b1;
    endtask : glitch
endmodule : serial_tx_model

// ===== async_serial_receiver_tb_top.sv
// Self-checking bench for the serial receiver over APB.
// Assumes the transmitter model shares pclk; divisor 1 gives 32 clocks a bit.
`timescale 1ns/100ps
module async_serial_receiver_tb_top;
    import async_rx_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, rxd, rif, irq, err;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;

    // Free-running 40 MHz clock
    initial begin
        forever #12.5 pclk = ~pclk;
    end

    async_serial_receiver i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_receive_pin(rxd), .receive_interrupt_flag(rif), .irq(irq));
    serial_tx_model #(.BIT_CLKS(32)) i_tx (.pclk(pclk), .line(rxd));

    // Compare and count
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One APB transfer; held until pready seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Sample pready at each rising edge; the hang guard ends a stuck wait
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        // Answer taken and request released at the same edge
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Read a register and compare
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, rd, exp);
    endtask : rdchk

    task automatic clks(input int n);
        repeat (n) @(posedge pclk);
    endtask : clks

    // Reset values and an unmapped address
    task automatic t_reset();
        rdchk(ctrl_offset, {28'h0, ctrl_reset}, "ctrl");
        rdchk(baud_offset, {16'h0, baud_reset}, "baud");
        rdchk(int_enable_offset, {29'h0, int_enable_reset}, "int_enable");
        apb(1'b0, 8'h1C, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        chk("unmapped", rd, 32'h0);
        $display("test reset done");
    endtask : t_reset

    // One character, masked then enabled interrupt, clear, pop
    task automatic t_basic();
        apb(1'b1, baud_offset, 32'h1);
        apb(1'b1, ctrl_offset, 32'h3);
        i_tx.send(9'h0A5, 8, 1'b1);
        clks(4);
        chk("flag", {31'h0, rif}, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        rdchk(int_status_offset, 32'h1, "int_status");
        apb(1'b1, int_enable_offset, 32'h1);
        clks(3);
        chk("irq on", {31'h0, irq}, 32'h1);
        apb(1'b1, int_clear_offset, 32'h7);
        clks(3);
        chk("irq off", {31'h0, irq}, 32'h0);
        rdchk(data_offset, 32'hA5, "data");
        clks(2);
        chk("flag pop", {31'h0, rif}, 32'h0);
        rdchk(status_offset, 32'h0, "status");
        $display("test basic done");
    endtask : t_basic

    // Short start pulse is dropped silently, next frame still taken
    task automatic t_abort();
        i_tx.glitch(4);
        clks(80);
        rdchk(status_offset, 32'h0, "status");
        rdchk(int_status_offset, 32'h0, "int_status");
        i_tx.send(9'h05A, 8, 1'b1);
        clks(4);
        rdchk(data_offset, 32'h5A, "data");
        $display("test abort done");
    endtask : t_abort

    // Bad stop then good character; error follows the head entry
    task automatic t_frame();
        apb(1'b1, int_clear_offset, 32'h7);
        i_tx.send(9'h03C, 8, 1'b0);
        clks(32);
        i_tx.send(9'h0C3, 8, 1'b1);
        clks(4);
        rdchk(status_offset, 32'h3, "status");
        rdchk(int_status_offset, 32'h3, "int_status");
        rdchk(data_offset, 32'h3C, "data");
        rdchk(status_offset, 32'h1, "status");
        rdchk(data_offset, 32'hC3, "data");
        $display("test frame done");
    endtask : t_frame

    // Third character shifts while full, then overrun halts intake
    task automatic t_overrun();
        apb(1'b1, int_clear_offset, 32'h7);
        i_tx.send(9'h011, 8, 1'b1);
        i_tx.send(9'h022, 8, 1'b1);
        fork
            i_tx.send(9'h033, 8, 1'b1);
            begin
                clks(150);
                rdchk(status_offset, 32'h9, "busy");
            end
        join
        clks(4);
        rdchk(status_offset, 32'h5, "status");
        rdchk(int_status_offset, 32'h5, "int_status");
        i_tx.send(9'h044, 8, 1'b1);
        clks(4);
        rdchk(data_offset, 32'h11, "data");
        rdchk(data_offset, 32'h22, "data");
        rdchk(data_offset, 32'h0, "empty");
        apb(1'b1, ctrl_offset, 32'h0);
        apb(1'b1, ctrl_offset, 32'h3);
        rdchk(status_offset, 32'h0, "status");
        i_tx.send(9'h066, 8, 1'b1);
        clks(4);
        rdchk(data_offset, 32'h66, "data");
        $display("test overrun done");
    endtask : t_overrun

    // Nine data bits
    task automatic t_nine();
        apb(1'b1, ctrl_offset, 32'hB);
        i_tx.send(9'h155, 9, 1'b1);
        clks(4);
        rdchk(data_offset, 32'h155, "data9");
        // synchronous select set: nothing is received
        apb(1'b1, ctrl_offset, 32'h7);
        i_tx.send(9'h00F, 8, 1'b1);
        clks(4);
        rdchk(status_offset, 32'h0, "sync off");
        apb(1'b1, ctrl_offset, 32'h3);
        $display("test nine done");
    endtask : t_nine

    // Counts and verdict, then stop
    task automatic final_report();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // Hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_basic();
        t_abort();
        t_frame();
        t_overrun();
        t_nine();
        final_report();
    end
endmodule : async_serial_receiver_tb_top
